// file: bench/msb_drive_model.sv
// Purpose: Ramp generator stand-in that drives the present output frequency.
// Assumes: One clk_sys domain.
// Notes: Coarse steps keep every stop short in simulation.
`timescale 1ns/1ps
module msb_drive_model import msb_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the sequencer
  input wire logic run_enable,
  input wire logic fast_stop_req,
  // Present frequency
  output logic [FREQ_W-1:0] out_freq
);
  // Climb while allowed, hold at the first step at or past full scale while running, fall otherwise, so the frequency reaches zero at a stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_freq <= '0;
    end else if (run_enable && !fast_stop_req && out_freq < FREQ_FULL) begin
      out_freq <= out_freq + 14'h0100;
    end else if (!run_enable || fast_stop_req) begin
      out_freq <= (out_freq > 14'h0200) ? out_freq - 14'h0200 : '0;
    end
  end
endmodule : msb_drive_model

// file: bench/tb_motor_stop_brake_sequencer.sv
// Purpose: Self-checking bench of the stop and brake sequencer.
// Assumes: Short tick of four clocks; pins change one edge after NBA drive.
// Notes: Reads are scored by a monitor that pops expected words from a queue.
`timescale 1ns/1ps
module tb_motor_stop_brake_sequencer import msb_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic run_pin = 1'b0;
  logic jog_pin = 1'b0;
  logic [3:0] mfi_pin = '0;
  logic [FREQ_W-1:0] out_freq;
  logic [ADC_W-1:0] analog_two_level = '0;
  logic out_enable, run_enable, fast_stop_req, brake_req;
  logic [TMR_W-1:0] fast_stop_time;
  logic [6:0] brake_level;
  logic [31:0] exp_q[$]; // Expected read words, oldest first
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Clock of 5 ns period
  always #2.5 clk_sys = ~clk_sys;
  msb_sequencer #(.NUM_MFI(4), .TICK_CYCLES(4)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_pin(run_pin), .jog_pin(jog_pin),
    .mfi_pin(mfi_pin), .out_freq(out_freq), .analog_two_level(analog_two_level),
    .out_enable(out_enable), .run_enable(run_enable), .fast_stop_req(fast_stop_req),
    .fast_stop_time(fast_stop_time), .brake_req(brake_req), .brake_level(brake_level));
  msb_drive_model u_model (.clk_sys(clk_sys), .rst(rst), .run_enable(run_enable),
    .fast_stop_req(fast_stop_req), .out_freq(out_freq));
  // Compare one value and count it
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Verdict and end of run
  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Let one edge pass so a following call never reassigns these in the same step
    @(posedge clk_sys);
  endtask : bus
  // Read with its expected word queued for the monitor
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, '0);
  endtask : rd
  // Let pins pass the synchroniser and the state register settle
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : settle
  // Monitor: score read data at the accepting edge
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      check("readdata", avs_readdata, exp_q.pop_front());
    end
  end
  // Timeout: whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    logic [6:0] pct;
    void'($urandom(32'h7c25));
    settle(3);
    rst <= 1'b0;
    settle(2);
    check("brake_level", {25'h0, brake_level}, 32'h32);
    check("fast_stop_time", {12'h0, fast_stop_time}, 32'h3e8);
    rd(OFS_BRAKE_PCT, 32'h32);
    rd(OFS_START_TIME, 32'h0);
    rd(OFS_STOP_TIME, 32'h32);
    rd(OFS_FAST_TIME, 32'h64);
    rd(6'h3c, 32'h0);
    bus(1'b1, OFS_BRAKE_PCT, 32'hc8);
    rd(OFS_BRAKE_PCT, 32'h64);
    pct = 7'($urandom % 101);
    bus(1'b1, OFS_BRAKE_PCT, {25'h0, pct});
    rd(OFS_BRAKE_PCT, {25'h0, pct});
    bus(1'b1, OFS_STOP_CFG, 32'h102);
    bus(1'b1, OFS_BLANK_TIME, 32'h2);
    bus(1'b1, OFS_STOP_TIME, 32'h3);
    bus(1'b1, OFS_START_TIME, 32'h2);
    run_pin <= 1'b1;
    settle(6);
    check("start brake", {brake_req, run_enable}, 32'h2);
    settle(40);
    check("running", {brake_req, run_enable}, 32'h1);
    run_pin <= 1'b0;
    settle(6);
    check("blanked", {out_enable, brake_req}, 32'h0);
    settle(12);
    check("stop brake", {out_enable, brake_req}, 32'h3);
    settle(60);
    check("brake scaled", {out_enable, brake_req}, 32'h3);
    settle(140);
    check("stopped", {out_enable, brake_req}, 32'h0);
    bus(1'b1, OFS_ANA_FUNC, 32'h6);
    bus(1'b1, OFS_MFI_ASSIGN, 32'h0f3c);
    analog_two_level <= ADC_FULL;
    mfi_pin <= 4'h1;
    settle(6);
    check("term brake", {brake_req, brake_level}, {24'h0, 1'b1, 7'h64});
    jog_pin <= 1'b1;
    settle(6);
    check("brake cancel", {brake_req, run_enable}, 32'h1);
    analog_two_level <= 12'($urandom);
    mfi_pin <= 4'h2;
    settle(6);
    check("fast stop", {fast_stop_req, run_enable}, 32'h2);
    settle(40);
    check("fast stop done", {out_enable, run_enable}, 32'h0);
    jog_pin <= 1'b0;
    mfi_pin <= 4'h0;
    settle(10);
    check("fast stop cleared", {fast_stop_req, out_enable}, 32'h0);
    bus(1'b1, OFS_STOP_CFG, 32'h3);
    run_pin <= 1'b1;
    settle(20);
    check("fast_stop_time", {12'h0, fast_stop_time}, 32'h64);
    run_pin <= 1'b0;
    settle(6);
    check("coast cut", {out_enable, run_enable}, 32'h0);
    run_pin <= 1'b1;
    settle(20);
    check("coast lockout", {brake_req, run_enable}, 32'h0);
    settle(100);
    check("coast restart", {brake_req, run_enable}, 32'h1);
    close_out();
  end
endmodule : tb_motor_stop_brake_sequencer

// file: hdl/msb_pkg.sv
// Purpose: Shared constants and types for the motor stop and brake sequencer.
// Assumes: 200 MHz system clock, times kept in hundredths of a second.
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
package msb_pkg;

  // Clock and base tick (one tick is a hundredth of a second)
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned TICK_TIME_MS = 10;
  localparam int unsigned TICK_CYCLES_DFLT = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int TMR_W = 20;

  // Output frequency scale: 10000 means 100.00 % of maximum frequency
  localparam int FREQ_W = 14;
  localparam logic [13:0] FREQ_FULL = 14'h2710;
  localparam logic [13:0] FREQ_BRAKE_FLOOR = 14'h03e8;
  localparam logic [13:0] FREQ_BRAKE_DIV = 14'h03e8;

  // Analog input: full scale (10 V or 20 mA) is the top code
  localparam int ADC_W = 12;
  localparam logic [11:0] ADC_FULL = 12'hfff;
  localparam logic [11:0] ADC_HALF = 12'h7ff;

  // Register byte offsets
  localparam logic [5:0] OFS_STOP_CFG = 6'h00;
  localparam logic [5:0] OFS_BRAKE_PCT = 6'h04;
  localparam logic [5:0] OFS_START_TIME = 6'h08;
  localparam logic [5:0] OFS_STOP_TIME = 6'h0c;
  localparam logic [5:0] OFS_BLANK_TIME = 6'h10;
  localparam logic [5:0] OFS_FAST_TIME = 6'h14;
  localparam logic [5:0] OFS_DECEL_TIME = 6'h18;
  localparam logic [5:0] OFS_MFI_ASSIGN = 6'h1c;
  localparam logic [5:0] OFS_ANA_FUNC = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;

  // Field positions
  localparam int METHOD_LSB = 0;
  localparam int UNIT_BIT = 8;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_FREQ_LSB = 16;

  // Reset values and limits
  localparam logic UNIT_RST = 1'b1;
  localparam logic [6:0] BRAKE_PCT_RST = 7'h32;
  localparam logic [6:0] BRAKE_PCT_MAX = 7'h64;
  localparam logic [9:0] START_TIME_RST = 10'h000;
  localparam logic [9:0] STOP_TIME_RST = 10'h032;
  localparam logic [9:0] BLANK_TIME_RST = 10'h032;
  localparam logic [9:0] BRAKE_TIME_MAX = 10'h3e8;
  localparam logic [15:0] FAST_TIME_RST = 16'h0064;
  localparam logic [15:0] DECEL_TIME_RST = 16'h0064;
  localparam logic [15:0] RAMP_TIME_MAX = 16'hea60;
  localparam logic [31:0] MFI_ASSIGN_RST = 32'h0000_0000;
  localparam logic [4:0] ANA_FUNC_RST = 5'h1f;
  localparam logic [19:0] TENTHS_TO_HUND = 20'h0000a;

  // Function codes of the terminals and the second analog input
  localparam logic [7:0] MFI_CODE_DC_BRAKE = 8'h3c;
  localparam logic [7:0] MFI_CODE_FSTOP_NO = 8'h0f;
  localparam logic [7:0] MFI_CODE_FSTOP_NC = 8'h11;
  localparam logic [4:0] ANA_FUNC_BRAKE = 5'h06;

  // Stop method encodings
  typedef enum logic [1:0] {
    STOP_RAMP = 2'b00,
    STOP_COAST = 2'b01,
    STOP_DC_BRAKE = 2'b10,
    STOP_TIMED_COAST = 2'b11
  } msb_method_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START_BRAKE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_DECEL = 4'b0011,
    ST_BLANK = 4'b0100,
    ST_STOP_BRAKE = 4'b0101,
    ST_TIMED_COAST = 4'b0110,
    ST_FAST_STOP = 4'b0111,
    ST_TERM_BRAKE = 4'b1000
  } msb_state_t;

endpackage : msb_pkg

// file: hdl/msb_sequencer.sv
// Purpose: Stop, start-brake, terminal-brake and fast-stop sequencer of a motor drive.
// Assumes: out_freq and analog_two_level come from logic on clk_sys; terminals are pins.
// Notes: Ramp generation is outside; this block only requests ramp, coast and brake.
// Summary of operation
// - DC stop: blank output, then inject brake current
// - Stop brake time scales with stop frequency
// - Timed coast cuts output at once
// - Timed coast ignores run for computed interval
// - Start brake runs set time; zero skips
// - Start brake time 0 to 10.00 s, default 0
// - Brake current 0 to 100 %, default 50
// - Terminal code 60 brakes while stopped
// - Run or jog cancels terminal brake
// - Analog code 6 sets brake current level
// - Analog full scale means 100 % current
// - Codes 15/17 fast stop, open/closed logic
// - After fast stop, no restart until stopped
// - Fast stop time 0 to 6000.0 s, default 10
// - Unit select zero means hundredths of seconds
// - Method codes: ramp, coast, DC, timed coast
// - Zero stop brake time disables stop injection
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module msb_sequencer import msb_pkg::*; #(
  parameter int unsigned NUM_MFI = 4,
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Control terminals (asynchronous pins)
  input wire logic run_pin,
  input wire logic jog_pin,
  input wire logic [NUM_MFI-1:0] mfi_pin,
  // Drive datapath inputs
  input wire logic [FREQ_W-1:0] out_freq,
  input wire logic [ADC_W-1:0] analog_two_level,
  // Requests to ramp generator and power stage
  output logic out_enable,
  output logic run_enable,
  output logic fast_stop_req,
  output logic [TMR_W-1:0] fast_stop_time,
  output logic brake_req,
  output logic [6:0] brake_level
);

  // The assignment register holds one 8-bit code per terminal
  if (NUM_MFI < 1 || NUM_MFI > 4) begin : g_bad_mfi
    $error("msb_sequencer: NUM_MFI must be 1 to 4");
  end

  // Hundredths from a ramp-time value under the selected unit
  function automatic logic [TMR_W-1:0] to_hund(input logic [15:0] v, input logic unit);
    logic [TMR_W-1:0] w;
    w = TMR_W'(v);
    to_hund = unit ? TMR_W'(w * TENTHS_TO_HUND) : w;
  endfunction : to_hund

  // Software settings
  msb_method_t method_reg; // Stop method
  logic unit_reg; // 0 hundredths, 1 tenths
  logic [6:0] brake_pct_reg; // Fixed brake current
  logic [9:0] start_time_reg; // Brake time at start
  logic [9:0] stop_time_reg; // Brake time at stop
  logic [9:0] blank_time_reg; // Minimum output blanking
  logic [15:0] fast_time_reg; // Fast stop ramp time
  logic [15:0] decel_time_reg; // Normal decel time
  logic [31:0] mfi_assign_reg; // Terminal function codes
  logic [4:0] ana_func_reg; // Second analog function
  // Copies frozen while running
  msb_method_t act_method_reg;
  logic act_unit_reg;
  logic [6:0] act_pct_reg;
  logic [9:0] act_stop_reg;
  logic [9:0] act_blank_reg;
  logic [15:0] act_decel_reg;
  logic [15:0] act_fast_reg;
  logic [4:0] act_ana_reg;
  // Sequencer
  msb_state_t state_reg, state_next;
  logic [FREQ_W-1:0] freq_stop_reg; // Frequency at stop instant
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  // Bus
  logic wait_reg;
  logic [31:0] rd_mux;
  // Terminals
  logic [NUM_MFI+1:0] pin_meta_reg, pin_sync_reg;
  logic run_any, term_brake, fs_any;
  logic [NUM_MFI-1:0] tb_vec, fs_vec;
  // Derived values
  logic [FREQ_W-1:0] brake_f;
  logic [TMR_W-1:0] stop_dur, coast_dur;
  logic [6:0] ana_pct, level_sel;

  msb_tmr_if tif ();

  msb_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .tif(tif)
  );
  assign tif.load = tmr_load;
  assign tif.load_val = tmr_val;

  // Two-stage synchronisers for all terminal pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {jog_pin, run_pin, mfi_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Jog counts as a run request
  assign run_any = pin_sync_reg[NUM_MFI] | pin_sync_reg[NUM_MFI+1];

  // Terminal function decode, one slice per input
  for (genvar gi = 0; gi < NUM_MFI; gi++) begin : g_mfi
    logic [7:0] code;
    assign code = mfi_assign_reg[8*gi +: 8];
    assign tb_vec[gi] = (code == MFI_CODE_DC_BRAKE) && pin_sync_reg[gi];
    // Normally open is active high, normally closed active low
    assign fs_vec[gi] = ((code == MFI_CODE_FSTOP_NO) && pin_sync_reg[gi]) ||
                        ((code == MFI_CODE_FSTOP_NC) && !pin_sync_reg[gi]);
  end
  assign term_brake = |tb_vec;
  assign fs_any = |fs_vec;

  // Stop injection lengthens with stop frequency, never below set time
  assign brake_f = (freq_stop_reg < FREQ_BRAKE_FLOOR) ? FREQ_BRAKE_FLOOR : freq_stop_reg;
  assign stop_dur = TMR_W'((32'(act_stop_reg) * 32'(brake_f)) / 32'(FREQ_BRAKE_DIV));
  // Coast block time: decel time scaled by frequency at stop
  assign coast_dur = to_hund(16'((32'(act_decel_reg) * 32'(out_freq)) / 32'(FREQ_FULL)),
                             act_unit_reg);
  // Analog level, rounded, full scale giving 100 %
  assign ana_pct = 7'((32'(analog_two_level) * 32'(BRAKE_PCT_MAX) + 32'(ADC_HALF)) /
                      32'(ADC_FULL));
  assign level_sel = (act_ana_reg == ANA_FUNC_BRAKE) ? ana_pct : act_pct_reg;

  // Next-state logic and timer loads
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_reg)
      ST_IDLE: begin
        // Live settings apply here; they are frozen on leaving
        if (run_any && !fs_any) begin
          if (start_time_reg != '0) begin
            state_next = ST_START_BRAKE;
            tmr_load = 1'b1;
            tmr_val = TMR_W'(start_time_reg);
          end else begin
            state_next = ST_RUN;
          end
        end else if (term_brake) begin
          state_next = ST_TERM_BRAKE;
        end
      end
      ST_START_BRAKE: begin
        if (!run_any) begin
          state_next = ST_IDLE;
        end else if (tif.expired) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fs_any) begin
          state_next = ST_FAST_STOP;
        end else if (!run_any) begin
          unique case (act_method_reg)
            STOP_RAMP: state_next = ST_DECEL;
            STOP_COAST, STOP_DC_BRAKE: begin
              state_next = ST_BLANK;
              tmr_load = 1'b1;
              tmr_val = TMR_W'(act_blank_reg);
            end
            STOP_TIMED_COAST: begin
              state_next = ST_TIMED_COAST;
              tmr_load = 1'b1;
              tmr_val = coast_dur;
            end
          endcase
        end
      end
      ST_DECEL: begin
        if (fs_any) begin
          state_next = ST_FAST_STOP;
        end else if (run_any) begin
          state_next = ST_RUN;
        end else if (out_freq == '0) begin
          state_next = ST_IDLE;
        end
      end
      ST_BLANK: begin
        if (tif.expired) begin
          // Zero stop time or plain coast ends without injection
          if (act_method_reg == STOP_DC_BRAKE && act_stop_reg != '0) begin
            state_next = ST_STOP_BRAKE;
            tmr_load = 1'b1;
            tmr_val = stop_dur;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_STOP_BRAKE: begin
        if (tif.expired) begin
          state_next = ST_IDLE;
        end
      end
      ST_TIMED_COAST: begin
        // Run requests have no effect until the interval ends
        if (tif.expired) begin
          state_next = ST_IDLE;
        end
      end
      ST_FAST_STOP: begin
        // Held until stopped and both commands dropped
        if (out_freq == '0 && !run_any && !fs_any) begin
          state_next = ST_IDLE;
        end
      end
      ST_TERM_BRAKE: begin
        if (run_any) begin
          state_next = ST_RUN;
        end else if (!term_brake) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State register and stop-instant frequency capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      freq_stop_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RUN && state_next != ST_RUN) begin
        freq_stop_reg <= out_freq;
      end
    end
  end

  // Settings are frozen outside idle, since they may not change in motion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_method_reg <= STOP_RAMP;
      act_unit_reg <= UNIT_RST;
      act_pct_reg <= BRAKE_PCT_RST;
      act_stop_reg <= STOP_TIME_RST;
      act_blank_reg <= BLANK_TIME_RST;
      act_decel_reg <= DECEL_TIME_RST;
      act_fast_reg <= FAST_TIME_RST;
      act_ana_reg <= ANA_FUNC_RST;
    end else if (state_reg == ST_IDLE) begin
      act_method_reg <= method_reg;
      act_unit_reg <= unit_reg;
      act_pct_reg <= brake_pct_reg;
      act_stop_reg <= stop_time_reg;
      act_blank_reg <= blank_time_reg;
      act_decel_reg <= decel_time_reg;
      act_fast_reg <= fast_time_reg;
      act_ana_reg <= ana_func_reg;
    end
  end

  // Registered outputs follow the next state so they line up with state_reg
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_enable <= 1'b0;
      run_enable <= 1'b0;
      fast_stop_req <= 1'b0;
      brake_req <= 1'b0;
      brake_level <= '0;
      fast_stop_time <= '0;
    end else begin
      // Blanking and both coasts leave the output off
      out_enable <= (state_next inside {ST_RUN, ST_DECEL, ST_START_BRAKE, ST_STOP_BRAKE,
                     ST_TERM_BRAKE}) || (state_next == ST_FAST_STOP && out_freq != '0);
      run_enable <= (state_next == ST_RUN);
      fast_stop_req <= (state_next == ST_FAST_STOP);
      brake_req <= (state_next inside {ST_START_BRAKE, ST_STOP_BRAKE, ST_TERM_BRAKE});
      brake_level <= level_sel;
      fast_stop_time <= to_hund(act_fast_reg, act_unit_reg);
    end
  end

  // One wait state per access keeps readdata a flop output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
    end
  end
  assign avs_waitrequest = wait_reg;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      OFS_STOP_CFG: rd_mux = {23'h0, unit_reg, 6'h0, method_reg};
      OFS_BRAKE_PCT: rd_mux = {25'h0, brake_pct_reg};
      OFS_START_TIME: rd_mux = {22'h0, start_time_reg};
      OFS_STOP_TIME: rd_mux = {22'h0, stop_time_reg};
      OFS_BLANK_TIME: rd_mux = {22'h0, blank_time_reg};
      OFS_FAST_TIME: rd_mux = {16'h0, fast_time_reg};
      OFS_DECEL_TIME: rd_mux = {16'h0, decel_time_reg};
      OFS_MFI_ASSIGN: rd_mux = mfi_assign_reg;
      OFS_ANA_FUNC: rd_mux = {27'h0, ana_func_reg};
      OFS_STATUS: rd_mux = {2'h0, freq_stop_reg, 1'b0, brake_level, fast_stop_req, brake_req,
                            run_enable, out_enable, state_reg};
      default: rd_mux = '0;
    endcase
  end

  // Read data is captured as waitrequest drops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && wait_reg) begin
      avs_readdata <= rd_mux;
    end
  end

  // Register writes, clamped to their legal ranges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      method_reg <= STOP_RAMP;
      unit_reg <= UNIT_RST;
      brake_pct_reg <= BRAKE_PCT_RST;
      start_time_reg <= START_TIME_RST;
      stop_time_reg <= STOP_TIME_RST;
      blank_time_reg <= BLANK_TIME_RST;
      fast_time_reg <= FAST_TIME_RST;
      decel_time_reg <= DECEL_TIME_RST;
      mfi_assign_reg <= MFI_ASSIGN_RST;
      ana_func_reg <= ANA_FUNC_RST;
    end else if (avs_write && !wait_reg) begin
      unique case (avs_address)
        OFS_STOP_CFG: begin
          method_reg <= msb_method_t'(avs_writedata[METHOD_LSB +: 2]);
          unit_reg <= avs_writedata[UNIT_BIT];
        end
        OFS_BRAKE_PCT: brake_pct_reg <= (avs_writedata > 32'(BRAKE_PCT_MAX)) ?
                                        BRAKE_PCT_MAX : avs_writedata[6:0];
        OFS_START_TIME: start_time_reg <= (avs_writedata > 32'(BRAKE_TIME_MAX)) ?
                                          BRAKE_TIME_MAX : avs_writedata[9:0];
        OFS_STOP_TIME: stop_time_reg <= (avs_writedata > 32'(BRAKE_TIME_MAX)) ?
                                        BRAKE_TIME_MAX : avs_writedata[9:0];
        OFS_BLANK_TIME: blank_time_reg <= (avs_writedata > 32'(BRAKE_TIME_MAX)) ?
                                          BRAKE_TIME_MAX : avs_writedata[9:0];
        OFS_FAST_TIME: fast_time_reg <= (avs_writedata > 32'(RAMP_TIME_MAX)) ?
                                        RAMP_TIME_MAX : avs_writedata[15:0];
        OFS_DECEL_TIME: decel_time_reg <= (avs_writedata > 32'(RAMP_TIME_MAX)) ?
                                          RAMP_TIME_MAX : avs_writedata[15:0];
        OFS_MFI_ASSIGN: mfi_assign_reg <= avs_writedata;
        OFS_ANA_FUNC: ana_func_reg <= avs_writedata[4:0];
        default: ;
      endcase
    end
  end

  // Checks on the sequencing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_blank_no_drive: assert property (state_reg == ST_BLANK |-> !out_enable && !brake_req)
    else $error("output driven during blanking");
  a_blank_then_brake: assert property ((state_reg == ST_BLANK) &&
    (state_next == ST_STOP_BRAKE) |-> act_method_reg == STOP_DC_BRAKE && tif.expired)
    else $error("stop injection without blanking");
  a_zero_stop_skip: assert property ((state_reg == ST_BLANK && act_stop_reg == '0)
    |-> state_next != ST_STOP_BRAKE)
    else $error("stop injection with zero time");
  a_coast_cut: assert property ((state_reg == ST_RUN && !run_any && !fs_any &&
    act_method_reg == STOP_TIMED_COAST) |=> state_reg == ST_TIMED_COAST && !out_enable)
    else $error("timed coast did not cut output");
  a_coast_block: assert property (state_reg == ST_TIMED_COAST && !tif.expired
    |=> state_reg == ST_TIMED_COAST)
    else $error("left timed coast early");
  a_zero_start_skip: assert property ((state_reg == ST_IDLE) &&
    (state_next == ST_START_BRAKE) |-> start_time_reg != '0)
    else $error("start brake with zero time");
  a_level_limit: assert property (brake_level <= BRAKE_PCT_MAX)
    else $error("brake level above full");
  a_term_cancel: assert property ((state_reg == ST_TERM_BRAKE && run_any)
    |=> state_reg == ST_RUN && run_enable && !brake_req)
    else $error("run did not cancel terminal brake");
  a_fast_hold: assert property ((state_reg == ST_FAST_STOP && out_freq != '0)
    |=> state_reg == ST_FAST_STOP)
    else $error("restart before stop");
  a_wait_single: assert property ((avs_read || avs_write) && !avs_waitrequest
    |=> avs_waitrequest)
    else $error("waitrequest low twice");

endmodule : msb_sequencer

// file: hdl/msb_timer.sv
// Purpose: Hundredth-second tick and down counter for all timed intervals.
// Assumes: TICK_CYCLES clocks make one hundredth of a second.
// Notes: Loading restarts the prescaler so every interval is whole ticks.
`timescale 1ns/1ps
module msb_timer import msb_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control side
  msb_tmr_if.tmr tif
);
  localparam int PRE_W = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  // A prescaler of one cycle cannot mark a tick apart from a load
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("msb_timer: TICK_CYCLES must be at least 2");
  end

  logic [PRE_W-1:0] pre_reg; // Prescaler
  logic [TMR_W-1:0] count_reg; // Ticks left
  logic expired_reg; // Mirrors count_reg == 0
  logic tick; // One hundredth has passed

  assign tick = (pre_reg == PRE_LAST) && !tif.load;
  assign tif.expired = expired_reg;

  // Prescaler, restarted by every load
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_reg <= '0;
    end else if (tif.load || pre_reg == PRE_LAST) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  // Down counter and its expiry flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      expired_reg <= 1'b1;
    end else if (tif.load) begin
      count_reg <= tif.load_val;
      expired_reg <= (tif.load_val == '0);
    end else if (tick && count_reg != '0) begin
      count_reg <= count_reg - TMR_W'(1);
      expired_reg <= (count_reg == TMR_W'(1));
    end
  end

endmodule : msb_timer

// file: hdl/msb_tmr_if.sv
// Purpose: Load and expiry signals between the sequencer and its timer.
// Assumes: Both ends run on clk_sys.
// Notes: load is a one-cycle pulse; expired is a level.
`timescale 1ns/1ps
interface msb_tmr_if;
  import msb_pkg::*;
  logic load; // Start a new interval
  logic [TMR_W-1:0] load_val; // Interval in hundredths
  logic expired; // Interval has run out
  modport ctl (output load, output load_val, input expired);
  modport tmr (input load, input load_val, output expired);
endinterface : msb_tmr_if
